// ### design/ddrct_cfg.svh
/*
  Register offsets, field ranges, reset values and codes of the DDR3
  configuration and timing block. Definitions only; included by the
  top module and the testbench.
*/
`ifndef DDRCT_CFG_SVH
`define DDRCT_CFG_SVH
`define DDRCT_OFS_STATUS 8'h04
`define DDRCT_OFS_GEOM   8'h08
`define DDRCT_OFS_REFR   8'h10
`define DDRCT_OFS_TIM1   8'h18
`define DDRCT_OFS_TIM2   8'h1c
`define DDRCT_OFS_TIM3   8'h20
`define DDRCT_OFS_TIM4   8'h28
`define DDRCT_OFS_PMCTL  8'h38
`define DDRCT_GEOM_RST   32'h6000_6032
`define DDRCT_REFR_RST   32'h0000_515c
`define DDRCT_TIM1_RST   32'h0808_0317
`define DDRCT_TIM2_RST   32'h2004_0303
`define DDRCT_TIM3_RST   32'h0000_0204
`define DDRCT_TIM4_RST   32'h0000_493f
`define DDRCT_PMCTL_RST  32'h0000_0000
`define DDRCT_F_TYPE     31:29
`define DDRCT_F_WIDTH    15:14
`define DDRCT_F_CL       13:9
`define DDRCT_F_INTERNAL_BANK_COUNT    6:4
`define DDRCT_F_CHIP_SELECT_COUNT    3
`define DDRCT_F_PAGE     2:0
`define DDRCT_F_SREF     31
`define DDRCT_F_RATE     15:0
`define DDRCT_F_HI       31:24
`define DDRCT_F_MH       23:16
`define DDRCT_F_ML       15:8
`define DDRCT_F_LO       7:0
`define DDRCT_F_LPMODE   10:8
`define DDRCT_F_PDTIM    7:0
`define DDRCT_TYPE_DDR3  3'h3
`define DDRCT_WIDTH_32   2'h1
`define DDRCT_LP_AUTO    3'h4
`define DDRCT_COL_BASE   4'h8
`define DDRCT_INIT_SHIFT 4
`endif

// ### design/ddrct_pkg.sv
/*
  Types of the DDR3 configuration and timing block: states, commands
  and the structs that carry bus, request, command and geometry.
  Assumes ddrct_cfg.svh is on the include path.
*/
package ddrct_pkg;
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_PDN  = 4'b0100,
    ST_SREF = 4'b1000
  } ddrct_state_e;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD  = 3'h2,
    CMD_WR  = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_ZQS = 3'h6,
    CMD_SRE = 3'h7
  } ddrct_cmd_e;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } ddrct_wbm_s;
  typedef struct packed {
    logic       valid;
    ddrct_cmd_e cmd;
    logic [2:0] bank;
    logic       cs;
  } ddrct_req_s;
  typedef struct packed {
    ddrct_cmd_e cmd;
    logic [2:0] bank;
    logic [1:0] cs_n;
  } ddrct_cmd_s;
  typedef struct packed {
    logic       ddr3;
    logic       bus32;
    logic [3:0] rd_lat;
    logic [2:0] bank_bits;
    logic [3:0] col_bits;
    logic       dual_cs;
  } ddrct_cfg_s;
endpackage : ddrct_pkg

// ### design/ddrct_top.sv
/*
  DDR3 configuration and timing enforcement: Wishbone register file,
  geometry decode, refresh timer, clock-enable control, power-down,
  self refresh and per-bank command spacing.
  Assumes a classic Wishbone master and a command source that holds
  its request until REQ_ACK; one clock, asynchronous reset.
*/
// The address map and the Wishbone interface to the registers are this design's own decisions.
// Functional notes
// - Type three selects DDR3 operation
// - Width code one selects 32-bit bus
// - Latency code 10h gives nine cycles
// - Bank code three gives eight banks
// - Single chip select: second never asserted
// - Page code two gives ten column bits
// - Periodic refresh from programmed interval
// - Interval scaled by sixteen during init
// - Clock enable low through init period
// - Software bit enters and leaves self refresh
// - Every timing field means cycles minus one
// - Cross-bank activates spaced by field plus one
// - Precharge to activate or refresh gap
// - Activate to read or write gap
// - Row open minimum and same-bank activate gap
// - Write to read and write recovery gaps
// - Read to precharge gap
// - Clock enable held field plus one cycles
// - Power-down exit gap before commands
// - Automatic power-down after idle count
`timescale 1ns/10ps
`include "ddrct_cfg.svh"
module ddrct_top #(
  parameter int NB = 8,
  parameter int CW = 8
) (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire ddrct_pkg::ddrct_wbm_s WB,
  output logic                    WB_ACK,
  output logic [31:0]             WB_DAT_O,
  input  wire ddrct_pkg::ddrct_req_s REQ,
  output logic                    REQ_ACK,
  output ddrct_pkg::ddrct_cmd_s   CMD,
  output logic                    CKE,
  output ddrct_pkg::ddrct_cfg_s   CFG,
  output logic                    INIT_DONE
);
  import ddrct_pkg::*;

  initial begin
    if (!(NB == 2 || NB == 4 || NB == 8) || CW < 8)
      $error("ddrct_top: NB must be 2, 4 or 8 and CW at least 8");
  end

  function automatic logic [CW-1:0] dn(input logic [CW-1:0] c);
    dn = (c == '0) ? c : c - 1'b1;
  endfunction : dn

  function automatic logic [CW-1:0] mx(input logic [CW-1:0] a,
                                       input logic [CW-1:0] b);
    mx = (a > b) ? a : b;
  endfunction : mx

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0]  s);
    for (int k = 0; k < 4; k++)
      merge[k*8 +: 8] = s[k] ? n[k*8 +: 8] : o[k*8 +: 8];
  endfunction : merge

  logic [31:0]  geom_q, refr_q, tim1_q, tim2_q, tim3_q, tim4_q, pm_q;
  logic         ack_q;
  logic [31:0]  dat_q;
  logic [31:0]  rd_data;
  ddrct_state_e st_q, st_d;
  logic         cke_q, cke_d;
  logic         init_q;
  logic         ref_pend_q;
  logic [19:0]  ref_c_q;
  logic [7:0]   idle_q;
  logic [CW-1:0] cke_c_q, xp_c_q, rrd_c_q, wtr_c_q, busy_c_q;
  logic [CW-1:0] rcd_c[NB];
  logic [CW-1:0] ras_c[NB];
  logic [CW-1:0] rc_c[NB];
  logic [CW-1:0] rp_c[NB];
  logic [CW-1:0] pre_c[NB];
  logic [NB-1:0] open_q;
  logic         ack_req_q;
  ddrct_cmd_s   cmd_q;
  ddrct_cfg_s   cfg_q;
  ddrct_cmd_e   nxt_cmd;
  logic [2:0]   nxt_bank;
  logic         nxt_cs;
  logic         grant;
  logic [NB-1:0] act_b, pre_b, rd_b, wr_b;
  logic         all_rp0;
  logic         vic_ok;
  logic [2:0]   vic_bank;

  // Register fields
  wire [CW-1:0] t_rp   = CW'(tim1_q[`DDRCT_F_HI]);
  wire [CW-1:0] activate_to_access_gap  = CW'(tim1_q[`DDRCT_F_MH]);
  wire [CW-1:0] t_wr   = CW'(tim1_q[`DDRCT_F_ML]);
  wire [CW-1:0] t_ras  = CW'(tim1_q[`DDRCT_F_LO]);
  wire [CW-1:0] t_rc   = CW'(tim2_q[`DDRCT_F_HI]);
  wire [CW-1:0] cross_bank_activate_gap  = CW'(tim2_q[`DDRCT_F_MH]);
  wire [CW-1:0] write_to_read_gap  = CW'(tim2_q[`DDRCT_F_ML]);
  wire [CW-1:0] read_to_precharge_gap  = CW'(tim2_q[`DDRCT_F_LO]);
  wire [CW-1:0] t_cke  = CW'(tim3_q[`DDRCT_F_ML]);
  wire [CW-1:0] t_xp   = CW'(tim3_q[`DDRCT_F_LO]);
  wire [CW-1:0] refresh_cycle_gap  = CW'(tim4_q[`DDRCT_F_ML]);
  wire [CW-1:0] t_zqs  = CW'(tim4_q[`DDRCT_F_LO]);
  wire [15:0]   rate   = refr_q[`DDRCT_F_RATE];
  wire          sr_req = refr_q[`DDRCT_F_SREF];
  wire [2:0]    low_power_select = pm_q[`DDRCT_F_LPMODE];
  wire [7:0]    idle_before_sleep_count = pm_q[`DDRCT_F_PDTIM];
  wire          chip_select_count  = geom_q[`DDRCT_F_CHIP_SELECT_COUNT];

  // Geometry decode
  wire          is_ddr3 = geom_q[`DDRCT_F_TYPE] == `DDRCT_TYPE_DDR3;
  wire          is_32 = geom_q[`DDRCT_F_WIDTH] == `DDRCT_WIDTH_32;
  wire [3:0]    rd_lat = geom_q[`DDRCT_F_CL] == 5'h0 ? 4'h0 :
                         4'(geom_q[13:10]) + 4'h1;
  wire [2:0]    bank_bits = geom_q[`DDRCT_F_INTERNAL_BANK_COUNT];
  wire [3:0]    col_bits = `DDRCT_COL_BASE +
                           4'(geom_q[`DDRCT_F_PAGE]);
  wire [2:0]    bank_mask = 3'((4'h1 << bank_bits) - 4'h1) &
                            3'(NB - 1);
  wire [2:0]    req_bank = REQ.bank & bank_mask;
  wire          req_cs = REQ.cs & chip_select_count;

  // Wishbone decode; a write lands on the edge that sees ack
  wire          wb_hit = WB.cyc & WB.stb;
  wire          wb_wr = wb_hit & WB.we & ack_q;
  wire [7:0]    wb_a = {WB.adr[7:2], 2'b00};
  wire [31:0]   status = {16'h0000, 8'(open_q), st_q,
                          ref_pend_q, cke_q, init_q, 1'b0};
  always_comb begin
    if (wb_a == `DDRCT_OFS_STATUS) rd_data = status;
    else if (wb_a == `DDRCT_OFS_GEOM) rd_data = geom_q;
    else if (wb_a == `DDRCT_OFS_REFR) rd_data = refr_q;
    else if (wb_a == `DDRCT_OFS_TIM1) rd_data = tim1_q;
    else if (wb_a == `DDRCT_OFS_TIM2) rd_data = tim2_q;
    else if (wb_a == `DDRCT_OFS_TIM3) rd_data = tim3_q;
    else if (wb_a == `DDRCT_OFS_TIM4) rd_data = tim4_q;
    else if (wb_a == `DDRCT_OFS_PMCTL) rd_data = pm_q;
    else rd_data = 32'h0000_0000;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_hit & ~ack_q;
      if (wb_hit & ~ack_q)
        dat_q <= rd_data;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      geom_q <= `DDRCT_GEOM_RST;
      refr_q <= `DDRCT_REFR_RST;
      tim1_q <= `DDRCT_TIM1_RST;
      tim2_q <= `DDRCT_TIM2_RST;
      tim3_q <= `DDRCT_TIM3_RST;
      tim4_q <= `DDRCT_TIM4_RST;
      pm_q   <= `DDRCT_PMCTL_RST;
    end else if (wb_wr) begin
      if (wb_a == `DDRCT_OFS_GEOM) geom_q <= merge(geom_q, WB.dat, WB.sel);
      if (wb_a == `DDRCT_OFS_REFR) refr_q <= merge(refr_q, WB.dat, WB.sel);
      if (wb_a == `DDRCT_OFS_TIM1) tim1_q <= merge(tim1_q, WB.dat, WB.sel);
      if (wb_a == `DDRCT_OFS_TIM2) tim2_q <= merge(tim2_q, WB.dat, WB.sel);
      if (wb_a == `DDRCT_OFS_TIM3) tim3_q <= merge(tim3_q, WB.dat, WB.sel);
      if (wb_a == `DDRCT_OFS_TIM4) tim4_q <= merge(tim4_q, WB.dat, WB.sel);
      if (wb_a == `DDRCT_OFS_PMCTL) pm_q <= merge(pm_q, WB.dat, WB.sel);
    end
  end

  // Refresh timer; the init period reuses the same counter scaled up
  wire [19:0] ref_lim = init_q ? {4'h0, rate} :
                        {rate, 4'h0};
  wire        ref_tick = (ref_c_q + 20'h1) >= ref_lim;

  // Bank bookkeeping and precharge-all victim
  always_comb begin
    all_rp0 = 1'b1;
    vic_ok = 1'b0;
    vic_bank = 3'h0;
    for (int i = NB - 1; i >= 0; i--) begin
      if (rp_c[i] != '0) all_rp0 = 1'b0;
      if (open_q[i] && ras_c[i] == '0 && pre_c[i] == '0) begin
        vic_ok = 1'b1;
        vic_bank = 3'(i);
      end
    end
  end

  wire b_open = open_q[req_bank];
  wire can_act = !b_open && rp_c[req_bank] == '0 &&
                 rc_c[req_bank] == '0 && rrd_c_q == '0;
  wire can_acc = b_open && rcd_c[req_bank] == '0;
  wire can_pre = b_open && ras_c[req_bank] == '0 &&
                 pre_c[req_bank] == '0;
  wire idle_bank = open_q == '0 && all_rp0;
  wire req_ok = (REQ.cmd == CMD_ACT) ? can_act :
                (REQ.cmd == CMD_RD)  ? can_acc && wtr_c_q == '0 :
                (REQ.cmd == CMD_WR)  ? can_acc :
                (REQ.cmd == CMD_PRE) ? can_pre :
                (REQ.cmd == CMD_ZQS) ? idle_bank : 1'b0;
  wire issue_ok = busy_c_q == '0 && xp_c_q == '0;
  wire cke_ok = cke_c_q == '0;

  always_comb begin
    st_d = st_q;
    cke_d = cke_q;
    nxt_cmd = CMD_NOP;
    nxt_bank = 3'h0;
    nxt_cs = 1'b0;
    grant = 1'b0;
    case (st_q)
      ST_INIT: begin
        if (ref_tick && cke_ok) begin
          st_d = ST_RUN;
          cke_d = 1'b1;
        end
      end
      ST_RUN: begin
        if (ref_pend_q && issue_ok) begin
          if (idle_bank) begin
            nxt_cmd = CMD_REF;
          end else if (vic_ok) begin
            nxt_cmd = CMD_PRE;
            nxt_bank = vic_bank;
          end
        end else if (sr_req && issue_ok && idle_bank && cke_ok) begin
          nxt_cmd = CMD_SRE;
          cke_d = 1'b0;
          st_d = ST_SREF;
        end else if (REQ.valid && !ack_req_q && !sr_req && issue_ok &&
                     req_ok && REQ.cmd != CMD_NOP) begin
          nxt_cmd = REQ.cmd;
          nxt_bank = req_bank;
          nxt_cs = req_cs;
          grant = 1'b1;
        end else if (low_power_select == `DDRCT_LP_AUTO && !REQ.valid &&
                     idle_q >= idle_before_sleep_count && cke_ok && issue_ok) begin
          cke_d = 1'b0;
          st_d = ST_PDN;
        end
      end
      ST_PDN: begin
        if ((REQ.valid || ref_pend_q || low_power_select != `DDRCT_LP_AUTO) &&
            cke_ok) begin
          cke_d = 1'b1;
          st_d = ST_RUN;
        end
      end
      ST_SREF: begin
        if (!sr_req && cke_ok) begin
          cke_d = 1'b1;
          st_d = ST_RUN;
        end
      end
      default: begin
        st_d = ST_INIT;
        cke_d = 1'b0;
      end
    endcase
  end

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      act_b[i] = nxt_cmd == CMD_ACT && nxt_bank == 3'(i);
      pre_b[i] = nxt_cmd == CMD_PRE && nxt_bank == 3'(i);
      rd_b[i]  = nxt_cmd == CMD_RD && nxt_bank == 3'(i);
      wr_b[i]  = nxt_cmd == CMD_WR && nxt_bank == 3'(i);
    end
  end

  // A counter loaded with a field reaches zero field plus one cycles on
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      open_q <= '0;
      for (int i = 0; i < NB; i++) begin
        rcd_c[i] <= '0;
        ras_c[i] <= '0;
        rc_c[i]  <= '0;
        rp_c[i]  <= '0;
        pre_c[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NB; i++) begin
        rcd_c[i] <= act_b[i] ? activate_to_access_gap : dn(rcd_c[i]);
        ras_c[i] <= act_b[i] ? t_ras : dn(ras_c[i]);
        rc_c[i]  <= act_b[i] ? t_rc : dn(rc_c[i]);
        rp_c[i]  <= pre_b[i] ? t_rp : dn(rp_c[i]);
        pre_c[i] <= rd_b[i] ? mx(dn(pre_c[i]), read_to_precharge_gap) :
                    wr_b[i] ? mx(dn(pre_c[i]), t_wr) :
                    dn(pre_c[i]);
        open_q[i] <= act_b[i] | (open_q[i] & ~pre_b[i]);
      end
    end
  end

  wire cke_edge = cke_d != cke_q;
  wire cke_rise = cke_d & ~cke_q;
  wire any_cmd = nxt_cmd != CMD_NOP;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cke_c_q  <= '0;
      xp_c_q   <= '0;
      rrd_c_q  <= '0;
      wtr_c_q  <= '0;
      busy_c_q <= '0;
    end else begin
      cke_c_q  <= cke_edge ? t_cke : dn(cke_c_q);
      xp_c_q   <= cke_rise ? t_xp : dn(xp_c_q);
      rrd_c_q  <= nxt_cmd == CMD_ACT ? cross_bank_activate_gap : dn(rrd_c_q);
      wtr_c_q  <= nxt_cmd == CMD_WR ? write_to_read_gap : dn(wtr_c_q);
      busy_c_q <= nxt_cmd == CMD_REF ? refresh_cycle_gap :
                  nxt_cmd == CMD_ZQS ? t_zqs : dn(busy_c_q);
    end
  end

  // Set wins over clear: a tick in the refresh cycle stays pending
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= ST_INIT;
      cke_q <= 1'b0;
      init_q <= 1'b0;
      ref_c_q <= 20'h0_0000;
      ref_pend_q <= 1'b0;
      idle_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cke_q <= cke_d;
      if (st_q == ST_INIT && st_d == ST_RUN)
        init_q <= 1'b1;
      ref_c_q <= ref_tick ? 20'h0_0000 : ref_c_q + 20'h1;
      if (ref_tick && st_q != ST_INIT)
        ref_pend_q <= 1'b1;
      else if (nxt_cmd == CMD_REF)
        ref_pend_q <= 1'b0;
      if (st_q != ST_RUN || REQ.valid || any_cmd)
        idle_q <= 8'h00;
      else if (idle_q != 8'hff)
        idle_q <= idle_q + 8'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cmd_q <= '{cmd: CMD_NOP, bank: 3'h0, cs_n: 2'b11};
      ack_req_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      cmd_q.cmd <= nxt_cmd;
      cmd_q.bank <= nxt_bank;
      cmd_q.cs_n <= !any_cmd ? 2'b11 :
                    nxt_cs ? 2'b01 : 2'b10;
      ack_req_q <= grant;
      cfg_q <= '{ddr3: is_ddr3, bus32: is_32, rd_lat: rd_lat,
                 bank_bits: bank_bits, col_bits: col_bits,
                 dual_cs: chip_select_count};
    end
  end

  assign WB_ACK = ack_q;
  assign WB_DAT_O = dat_q;
  assign REQ_ACK = ack_req_q;
  assign CMD = cmd_q;
  assign CKE = cke_q;
  assign CFG = cfg_q;
  assign INIT_DONE = init_q;

  // Checks on the command stream
  AST_CKE_INIT: assert property (@(posedge CLK) disable iff (RST)
    (st_q == ST_INIT) |-> !cke_q) else $error("cke high during init");
  AST_CS1_OFF: assert property (@(posedge CLK) disable iff (RST)
    !chip_select_count && $stable(chip_select_count) |=> cmd_q.cs_n[1])
    else $error("second chip select used");
  AST_CKE_HOLD: assert property (@(posedge CLK) disable iff (RST)
    $changed(cke_q) && t_cke != '0 |=> $stable(cke_q))
    else $error("cke width short");
  AST_XP_GAP: assert property (@(posedge CLK) disable iff (RST)
    $rose(cke_q) && t_xp != '0 |-> cmd_q.cmd == CMD_NOP ##1
    cmd_q.cmd == CMD_NOP) else $error("command inside exit gap");
  AST_RRD_GAP: assert property (@(posedge CLK) disable iff (RST)
    cmd_q.cmd == CMD_ACT && cross_bank_activate_gap != '0 |=> cmd_q.cmd != CMD_ACT)
    else $error("activates too close");
  AST_RFC_GAP: assert property (@(posedge CLK) disable iff (RST)
    cmd_q.cmd == CMD_REF && refresh_cycle_gap != '0 |=> cmd_q.cmd == CMD_NOP)
    else $error("command inside refresh cycle");
  AST_RP_GAP: assert property (@(posedge CLK) disable iff (RST)
    cmd_q.cmd == CMD_PRE && t_rp != '0 |=>
    !(cmd_q.cmd == CMD_ACT && cmd_q.bank == $past(cmd_q.bank)))
    else $error("activate inside precharge gap");
  AST_RCD_GAP: assert property (@(posedge CLK) disable iff (RST)
    cmd_q.cmd == CMD_ACT && activate_to_access_gap != '0 |=>
    !((cmd_q.cmd == CMD_RD || cmd_q.cmd == CMD_WR) &&
      cmd_q.bank == $past(cmd_q.bank))) else $error("access too early");
  AST_SREF_CKE: assert property (@(posedge CLK) disable iff (RST)
    cmd_q.cmd == CMD_SRE |-> !cke_q ##1 !cke_q)
    else $error("cke high in self refresh");
endmodule : ddrct_top

// ### tb/ddrct_mem_model.sv
/*
  Memory-side model for ddrct_top: watches CMD and CKE as a DDR3
  device would and reports command times, CKE runs and refresh spacing.
  Assumes ddrct_pkg is compiled first; drives nothing into the design.
*/
`timescale 1ns/10ps
module ddrct_mem_model (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ddrct_pkg::ddrct_cmd_s cmd,
  input  wire logic                  cke,
  output int                         t_cmd,
  output int                         t_rise,
  output int                         cke_min,
  output int                         ref_gap,
  output int                         ref_cnt,
  output bit                         sre_seen,
  output bit                         cs1_seen
);
  import ddrct_pkg::*;
  int now;
  int run;
  int t_ref;
  bit cke_q;
  bit hi_seen;
  // Falling edge, so the bench reads settled values at its rising edge
  always @(negedge clk) begin
    if (!rst) begin
      now++;
      if (cke !== cke_q) begin
        if (hi_seen && (cke_min == 0 || run < cke_min)) cke_min = run;
        if (cke === 1'b1) begin
          t_rise = now;
          hi_seen = 1'b1;
        end
        run = 0;
      end
      run++;
      cke_q = cke;
      if (cmd.cmd !== CMD_NOP) t_cmd = now;
      if (cmd.cs_n[1] === 1'b0) cs1_seen = 1'b1;
      if (cmd.cmd === CMD_REF) begin
        ref_gap = now - t_ref;
        t_ref = now;
        ref_cnt++;
      end
      if (cmd.cmd === CMD_SRE && cke === 1'b0) sre_seen = 1'b1;
    end
  end
endmodule : ddrct_mem_model

// ### tb/testbench.sv
/*
  Bench for ddrct_top: Wishbone and command-port tasks, then init,
  spacing, power-down, self-refresh and refresh-interval tests.
  Assumes ddrct_pkg, ddrct_cfg.svh and ddrct_mem_model.
*/
`timescale 1ns/10ps
`include "ddrct_cfg.svh"
module testbench;
  import ddrct_pkg::*;
  localparam int          LIMIT  = 20000;
  localparam logic [31:0] INIT_R = 32'h0000_0010;
  // 7.8 us at 250 MHz is 1950 cycles
  localparam logic [31:0] RATE   = 32'h0000_079e;
  // Cycle counts rounded up, minus one, as every timing field of the
  // block expects
  localparam logic [31:0] TIM1   = 32'h0504_0609;
  localparam logic [31:0] TIM2   = 32'h1203_0307;
  localparam logic [31:0] TIM3   = 32'h0000_0304;
  localparam logic [31:0] TIM4   = 32'h0000_050a;
  localparam int RP  = TIM1[31:24];
  localparam int RCD = TIM1[23:16];
  localparam int WR  = TIM1[15:8];
  localparam int RAS = TIM1[7:0];
  localparam int RC  = TIM2[31:24];
  localparam int RRD = TIM2[23:16];
  localparam int WTR = TIM2[15:8];
  localparam int RTP = TIM2[7:0];
  localparam int CKW = TIM3[15:8];
  localparam int XP  = TIM3[7:0];
  localparam int ZQ  = TIM4[7:0];
  logic        clk;
  logic        rst;
  ddrct_wbm_s  wb;
  logic        wb_ack;
  logic [31:0] wb_dat;
  ddrct_req_s  req;
  logic        req_ack;
  ddrct_cmd_s  cmd;
  logic        cke;
  ddrct_cfg_s  cfg;
  logic        init_done;
  int          t_cmd;
  int          t_rise;
  int          cke_min;
  int          ref_gap;
  int          ref_cnt;
  bit          sre_seen;
  bit          cs1_seen;
  int          miscompares;
  int          num_checks;
  int          cyc_n;
  int          t0;
  int          k;
  logic [31:0] rd;
  logic [1:0]  csn;
  logic        early;
  int          tt [13];
  ddrct_cmd_e  s_cmd [13] = '{CMD_ACT, CMD_ACT, CMD_WR, CMD_RD, CMD_PRE,
    CMD_ACT, CMD_PRE, CMD_ACT, CMD_WR, CMD_PRE, CMD_PRE, CMD_ZQS, CMD_ACT};
  int s_bank [13] = '{0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0};
  int s_ref  [13] = '{0, 0, 1, 2, 3, 4, 5, 5, 7, 8, 0, 0, 11};
  int s_gap  [13] = '{0, RRD + 1, RCD + 1, WTR + 1, RTP + 1, RP + 1,
    RAS + 1, RC + 1, RCD + 1, WR + 1, 0, 0, ZQ + 1};
  logic [7:0]  r_ofs [7] = '{`DDRCT_OFS_REFR, `DDRCT_OFS_GEOM,
    `DDRCT_OFS_TIM1, `DDRCT_OFS_TIM2, `DDRCT_OFS_TIM3, `DDRCT_OFS_TIM4,
    `DDRCT_OFS_PMCTL};
  logic [31:0] r_rst [7] = '{`DDRCT_REFR_RST, `DDRCT_GEOM_RST,
    `DDRCT_TIM1_RST, `DDRCT_TIM2_RST, `DDRCT_TIM3_RST, `DDRCT_TIM4_RST,
    `DDRCT_PMCTL_RST};
  logic [31:0] r_new [7] = '{INIT_R, `DDRCT_GEOM_RST, TIM1, TIM2, TIM3,
    TIM4, 32'h0};

  ddrct_top i_ddrct_top (.CLK(clk), .RST(rst), .WB(wb), .WB_ACK(wb_ack),
    .WB_DAT_O(wb_dat), .REQ(req), .REQ_ACK(req_ack), .CMD(cmd),
    .CKE(cke), .CFG(cfg), .INIT_DONE(init_done));
  ddrct_mem_model i_ddrct_mem_model (.clk(clk), .rst(rst), .cmd(cmd),
    .cke(cke), .t_cmd(t_cmd), .t_rise(t_rise), .cke_min(cke_min),
    .ref_gap(ref_gap), .ref_cnt(ref_cnt), .sre_seen(sre_seen),
    .cs1_seen(cs1_seen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == LIMIT) begin
      miscompares++;
      complete_run();
    end
  end

  // One classic cycle; waits for ack, then idles a cycle
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    wb <= {1'b1, 1'b1, w, s, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd = wb_dat;
    wb <= '0;
    @(posedge clk);
  endtask : wbx

  // Request held until granted; dropped for a cycle so it is not re-granted
  task automatic issue(input ddrct_cmd_e c, input logic [2:0] b,
                       input logic cs);
    int n;
    n = 0;
    req <= {1'b1, c, b, cs};
    do begin
      @(posedge clk);
      n++;
    end while (req_ack !== 1'b1 && n < 400);
    if (n >= 400) miscompares++;
    csn = cmd.cs_n;
    req <= '0;
    @(posedge clk);
  endtask : issue

  initial begin
    rst = 1'b1;
    wb = '0;
    req = '0;
    early = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t0 = cyc_n;
    for (int i = 0; i < 7; i++) begin
      wbx(1'b0, r_ofs[i], '0, 4'hf);
      check(rd, r_rst[i]);
      wbx(1'b1, r_ofs[i], r_new[i], 4'hf);
      wbx(1'b0, r_ofs[i], '0, 4'hf);
      check(rd, r_new[i]);
    end
    check(cfg, {1'b1, 1'b1, 4'h9, 3'h3, 4'ha, 1'b0});
    wbx(1'b1, 8'h40, 32'hffff_ffff, 4'hf);
    wbx(1'b0, 8'h40, '0, 4'hf);
    check(rd, 32'h0);
    wbx(1'b1, `DDRCT_OFS_PMCTL, 32'hffff_ffff, 4'h1);
    wbx(1'b0, `DDRCT_OFS_PMCTL, '0, 4'hf);
    check(rd, 32'h0000_00ff);
    wbx(1'b1, `DDRCT_OFS_PMCTL, '0, 4'hf);
    wbx(1'b0, `DDRCT_OFS_STATUS, '0, 4'hf);
    check({rd[7:4], rd[2:1]}, {4'h1, 2'b00});
    k = 0;
    while (init_done !== 1'b1 && k < 1000) begin
      if (cke !== 1'b0) early = 1'b1;
      @(posedge clk);
      k++;
    end
    check(early, 1'b0);
    check((cyc_n - t0) >= 16 * INIT_R - 8 &&
          (cyc_n - t0) <= 16 * INIT_R + 8, 1'b1);
    wbx(1'b1, `DDRCT_OFS_REFR, RATE, 4'hf);
    // Each step is raised as early as allowed, so the gap is the minimum
    for (int i = 0; i < 13; i++) begin
      issue(s_cmd[i], 3'(s_bank[i]), i == 0);
      tt[i] = t_cmd;
      if (i == 0) check(csn, 2'b10);
      if (s_gap[i] != 0) check(tt[i] - tt[s_ref[i]], s_gap[i]);
    end
    wbx(1'b1, `DDRCT_OFS_PMCTL, 32'h0000_0410, 4'hf);
    k = 0;
    while (cke !== 1'b0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    check(cke, 1'b0);
    issue(CMD_PRE, 3'h0, 1'b0);
    check(t_cmd - t_rise >= XP + 1, 1'b1);
    check(cke_min >= CKW + 1, 1'b1);
    wbx(1'b1, `DDRCT_OFS_PMCTL, '0, 4'hf);
    wbx(1'b1, `DDRCT_OFS_REFR, 32'h8000_0000 | RATE, 4'hf);
    k = 0;
    while (sre_seen !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    check(sre_seen, 1'b1);
    wbx(1'b0, `DDRCT_OFS_STATUS, '0, 4'hf);
    check(rd[7:4], 4'h8);
    wbx(1'b1, `DDRCT_OFS_REFR, RATE, 4'hf);
    k = 0;
    while (cke !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    check(cke, 1'b1);
    wbx(1'b1, `DDRCT_OFS_REFR, 32'h0000_0080, 4'hf);
    t0 = ref_cnt + 3;
    k = 0;
    while (ref_cnt < t0 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check(ref_gap, 32'h0000_0080);
    check(cs1_seen, 1'b0);
    complete_run();
  end
endmodule : testbench
